// ===== hw/psm_top.sv
// power-saving mode controller: idle and power-down entry, wake-up, pin states
// assumes apb register access on pclk, async pins synchronised here, cpu reacts to restart/vector pulses
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.svh"

module psm_top #(
    parameter int unsigned DEBOUNCE_CYC = `PSM_DEBOUNCE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reset_pin,
    input  wire logic        ext_irq_pin_zero,
    input  wire logic        ext_irq_pin_one,
    input  wire logic        irq_pending,
    input  wire logic        ext_mem_mode,
    output logic             cpu_clk_en,
    output logic             osc_en,
    output logic             addr_latch_strobe,
    output logic             program_fetch_strobe,
    output logic             port0_float,
    output logic             port2_addr,
    output logic [1:0]       irq_vector_req,
    output logic             cpu_restart,
    output logic [15:0]      restart_pc
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {reset_pin, ext_irq_pin_one, ext_irq_pin_zero};
            sync_b <= sync_a;
        end
    end
    logic rst_s;
    logic ext_irq_pin_one_s;
    logic ext_irq_pin_zero_s;
    assign rst_s  = sync_b[2];
    assign ext_irq_pin_one_s = sync_b[1];
    assign ext_irq_pin_zero_s = sync_b[0];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    psm_pkg::psm_state_t st;
    psm_pkg::psm_state_t next_st;

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wr,
                                              input logic [7:0] mask, input logic en);
        merge_byte = en ? ((old & ~mask) | (wr & mask)) : old;
    endfunction

    logic        acc;
    logic        wr;
    logic [7:0]  idx;
    logic        hit_pc;
    logic        hit_ie;
    logic        hit_cfg;
    logic        hit_st;
    logic        pin_wake0;
    logic        pin_wake1;
    assign acc     = psel && penable && st.pready;
    assign wr      = acc && pwrite;
    assign idx     = paddr[9:2];
    assign hit_pc  = (paddr[1:0] == 2'b00) && (idx == `PSM_IDX_PWR_CTRL) && (paddr[31:10] == 22'h00_0000);
    assign hit_ie  = (paddr[1:0] == 2'b00) && (idx == `PSM_IDX_IRQ_EN) && (paddr[31:10] == 22'h00_0000);
    assign hit_cfg = (paddr[1:0] == 2'b00) && (idx == `PSM_IDX_SYS_CFG) && (paddr[31:10] == 22'h00_0000);
    assign hit_st  = (paddr[1:0] == 2'b00) && (idx == `PSM_IDX_STATUS) && (paddr[31:10] == 22'h00_0000);
    // a pin wakes only with all three enables set
    assign pin_wake0 = ext_irq_pin_zero_s && st.regs.irq_en[`PSM_BIT_GIE] && st.regs.irq_en[`PSM_BIT_EX0]
                       && st.regs.sys_cfg[`PSM_BIT_PINWAKE];
    assign pin_wake1 = ext_irq_pin_one_s && st.regs.irq_en[`PSM_BIT_GIE] && st.regs.irq_en[`PSM_BIT_EX1]
                       && st.regs.sys_cfg[`PSM_BIT_PINWAKE];

    always_comb begin
        logic [7:0] wbyte;
        wbyte   = pwdata[7:0];
        next_st = st;
        next_st.irq_vector_req = 2'h0;
        next_st.cpu_restart    = 1'b0;
        // pready registered from the setup phase: no wait state, and prdata still a flop output
        next_st.pready  = psel && !penable;
        next_st.pslverr = psel && !penable && !(hit_pc || hit_ie || hit_cfg || hit_st);
        next_st.prdata  = 32'h0000_0000;
        if (psel && !penable) begin
            unique case (1'b1)
                // request bits read as zero, flags read back
                hit_pc:  next_st.prdata = {24'h00_0000, st.regs.pwr_ctrl & `PSM_POWER_MODE_CONTROL_RW_MASK};
                hit_ie:  next_st.prdata = {24'h00_0000, st.regs.irq_en};
                hit_cfg: next_st.prdata = {24'h00_0000, st.regs.sys_cfg};
                hit_st:  next_st.prdata = {30'h0000_0000, st.mode};
                default: next_st.prdata = 32'h0000_0000;
            endcase
        end
        if (wr && pstrb[0]) begin
            if (hit_pc) begin
                next_st.regs.pwr_ctrl = merge_byte(st.regs.pwr_ctrl, wbyte, `PSM_POWER_MODE_CONTROL_RW_MASK, 1'b1);
                if (st.mode == psm_pkg::PSM_RUN) begin
                    if (wbyte[`PSM_BIT_PDOWN]) begin
                        next_st.mode = psm_pkg::PSM_PDOWN;
                    end else if (wbyte[`PSM_BIT_IDLE]) begin
                        next_st.mode = psm_pkg::PSM_IDLE;
                    end
                end
            end
            if (hit_ie) begin
                next_st.regs.irq_en = merge_byte(st.regs.irq_en, wbyte, `PSM_IE_RW_MASK, 1'b1);
            end
            if (hit_cfg) begin
                next_st.regs.sys_cfg = merge_byte(st.regs.sys_cfg, wbyte, `PSM_CFG_RW_MASK, 1'b1);
            end
        end
        unique case (st.mode)
            psm_pkg::PSM_RUN: begin
            end
            psm_pkg::PSM_IDLE: begin
                if (rst_s) begin
                    next_st.mode        = psm_pkg::PSM_RUN;
                    next_st.regs        = '{`PSM_RST_POWER_MODE_CONTROL, `PSM_RST_IE, `PSM_RST_CFG};
                    next_st.cpu_restart = 1'b1;
                    next_st.restart_pc  = `PSM_RESET_VECTOR;
                end else if (irq_pending) begin
                    next_st.mode = psm_pkg::PSM_RUN;
                end
            end
            psm_pkg::PSM_PDOWN: begin
                // registers untouched while down
                if (rst_s) begin
                    next_st.mode          = psm_pkg::PSM_DEBOUNCE;
                    next_st.in_reset_wake = 1'b1;
                    next_st.cnt           = 32'h0000_0000;
                end else if (pin_wake0 || pin_wake1) begin
                    next_st.mode          = psm_pkg::PSM_DEBOUNCE;
                    next_st.wake_src      = {pin_wake1, pin_wake0 };
                    next_st.in_reset_wake = 1'b0;
                    next_st.cnt           = 32'h0000_0000;
                end
            end
            psm_pkg::PSM_DEBOUNCE: begin
                // cpu held until the oscillator has settled
                if (st.in_reset_wake && rst_s) begin
                    next_st.cnt = 32'h0000_0000;
                end else if (st.cnt < DEBOUNCE_CYC - 1) begin
                    next_st.cnt = st.cnt + 32'h0000_0001;
                end else begin
                    next_st.mode = psm_pkg::PSM_RUN;
                    if (st.in_reset_wake) begin
                        next_st.cpu_restart = 1'b1;
                        next_st.restart_pc  = `PSM_RESET_VECTOR;
                        next_st.regs        = '{`PSM_RST_POWER_MODE_CONTROL, `PSM_RST_IE, `PSM_RST_CFG};
                    end else begin
                        // pin zero has priority when both fired
                        next_st.irq_vector_req = st.wake_src[0] ? 2'b01 : 2'b10;
                    end
                end
            end
        endcase
        next_st.cpu_clk_en   = (next_st.mode == psm_pkg::PSM_RUN);
        next_st.osc_en       = (next_st.mode != psm_pkg::PSM_PDOWN);
        next_st.strobe_level = (next_st.mode == psm_pkg::PSM_IDLE);
        next_st.port0_float  = ext_mem_mode && (next_st.mode != psm_pkg::PSM_RUN);
        next_st.port2_addr   = ext_mem_mode && (next_st.mode == psm_pkg::PSM_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{mode: psm_pkg::PSM_RUN, regs: '{`PSM_RST_POWER_MODE_CONTROL, `PSM_RST_IE, `PSM_RST_CFG},
                    wake_src: 2'h0, cnt: 32'h0000_0000, prdata: 32'h0000_0000, pready: 1'b0,
                    pslverr: 1'b0, cpu_clk_en: 1'b1, osc_en: 1'b1, strobe_level: 1'b0,
                    port0_float: 1'b0, port2_addr: 1'b0, irq_vector_req: 2'h0, cpu_restart: 1'b0,
                    restart_pc: `PSM_RESET_VECTOR, in_reset_wake: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign prdata               = st.prdata;
    assign pready               = st.pready;
    assign pslverr              = st.pslverr;
    assign cpu_clk_en           = st.cpu_clk_en;
    assign osc_en               = st.osc_en;
    assign addr_latch_strobe    = st.strobe_level;
    assign program_fetch_strobe = st.strobe_level;
    assign port0_float          = st.port0_float;
    assign port2_addr           = st.port2_addr;
    assign irq_vector_req       = st.irq_vector_req;
    assign cpu_restart          = st.cpu_restart;
    assign restart_pc           = st.restart_pc;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    idle_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_pc && pstrb[0] && pwdata[0] && !pwdata[1] && st.mode == psm_pkg::PSM_RUN)
        |=> !cpu_clk_en && osc_en && addr_latch_strobe) else $error("idle entry wrong");
    pd_priority_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_pc && pstrb[0] && pwdata[1] && st.mode == psm_pkg::PSM_RUN)
        |=> !osc_en && !addr_latch_strobe) else $error("power-down not taken");
    req_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && $past(hit_pc)) |-> prdata[1:0] == 2'b00) else $error("request bits read nonzero");
    idle_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.mode == psm_pkg::PSM_IDLE && irq_pending && !rst_s) |=> cpu_clk_en) else $error("idle wake missed");
    idle_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.mode == psm_pkg::PSM_IDLE && rst_s) |=> cpu_restart && restart_pc == 16'h0000)
        else $error("idle reset missed");
    pd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.mode == psm_pkg::PSM_PDOWN) |=> $stable(st.regs)) else $error("registers changed in power-down");
    gate_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.mode == psm_pkg::PSM_PDOWN && !rst_s && !st.regs.sys_cfg[`PSM_BIT_PINWAKE]) |=> !cpu_clk_en)
        else $error("pin wake without enable");
    debounce_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.mode == psm_pkg::PSM_PDOWN && $rose(st.mode == psm_pkg::PSM_DEBOUNCE) == 1'b0
         && pin_wake0 && !rst_s) |=> !cpu_clk_en [*2]) else $error("cpu ran before de-bounce");

endmodule // psm_top
`default_nettype wire

// ===== hw/psm_regs.svh
// constants of the power-saving mode controller: register offsets, fields, reset values, timings
// assumes an apb master with 32-bit data; offsets are register indices, byte address is four times
//
// Contract
// - setting the idle request stops the cpu clock; peripherals keep clocking
// - idle request bit always reads back as zero
// - power-down request bit always reads back as zero
// - any enabled interrupt ends idle and restarts the cpu
// - reset input high during idle performs a full internal reset
// - setting the power-down request stops the oscillator
// - ram and special registers keep their contents during power-down
// - reset wake from power-down restarts execution at address 0000h
// - pin wake from power-down runs the matching interrupt routine
// - pin wake needs global enable, pin enable and sleep pin wake enable
// - pin wake from power-down only while sleep pin wake enable is one
// - pin wake waits a clock de-bounce period before the cpu runs
// - strobes high in idle, low in power-down; port 0 floats, port 2 address
// - two general flag bits at bits 3 and 2 read back freely
// - interrupt enable register holds global and two external pin enables
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define PSM_IDX_PWR_CTRL   8'h87
`define PSM_IDX_IRQ_EN     8'hA8
`define PSM_IDX_SYS_CFG    8'hBF
`define PSM_IDX_STATUS     8'hF0

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define PSM_BIT_IDLE       0
`define PSM_BIT_PDOWN      1
`define PSM_BIT_GF0        2
`define PSM_BIT_GF1        3
`define PSM_BIT_BAUD       7
`define PSM_BIT_EX0        0
`define PSM_BIT_EX1        2
`define PSM_BIT_GIE        7
`define PSM_BIT_PINWAKE    4
`define PSM_POWER_MODE_CONTROL_RW_MASK   8'h8C
`define PSM_IE_RW_MASK     8'hBF
`define PSM_CFG_RW_MASK    8'h13

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSM_RST_POWER_MODE_CONTROL       8'h00
`define PSM_RST_IE         8'h00
`define PSM_RST_CFG        8'h02
`define PSM_RESET_VECTOR   16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PSM_CLK_NS         10
`define PSM_DEBOUNCE_US    100
`define PSM_DEBOUNCE_CYC   ((`PSM_DEBOUNCE_US * 1000) / `PSM_CLK_NS)

`endif

// ===== hw/psm_pkg.sv
// types of the power-saving mode controller
// assumes psm_regs.svh for all numeric constants
package psm_pkg;

    typedef enum logic [1:0] {
        PSM_RUN,
        PSM_IDLE,
        PSM_PDOWN,
        PSM_DEBOUNCE
    } psm_mode_t;

    typedef struct packed {
        logic [7:0] pwr_ctrl;
        logic [7:0] irq_en;
        logic [7:0] sys_cfg;
    } psm_regs_t;

    typedef struct packed {
        psm_mode_t  mode;
        psm_regs_t  regs;
        logic [1:0] wake_src;
        logic [31:0] cnt;
        logic [31:0] prdata;
        logic       pready;
        logic       pslverr;
        logic       cpu_clk_en;
        logic       osc_en;
        logic       strobe_level;
        logic       port0_float;
        logic       port2_addr;
        logic [1:0] irq_vector_req;
        logic       cpu_restart;
        logic [15:0] restart_pc;
        logic       in_reset_wake;
    } psm_state_t;

endpackage

// ===== dv/psm_ext_model.sv
// far-side model: external reset pin and the two external interrupt pins
// assumes the bench raises a request for one pclk cycle or longer
`timescale 1ns/1ps
`default_nettype none
module psm_ext_model #(
    parameter int RST_HOLD = 12,
    parameter int PIN_HOLD = 4
) (
    input  wire logic       pclk,
    input  wire logic       rst_req,
    input  wire logic [1:0] pin_req,
    output logic            reset_pin,
    output logic            ext_irq_pin_zero,
    output logic            ext_irq_pin_one
);
    int rst_cnt = 0;
    int p0_cnt = 0;
    int p1_cnt = 0;
    // reset stands longer than the scaled de-bounce so the oscillator settles
    always @(posedge pclk) begin
        if (rst_req) rst_cnt <= RST_HOLD;
        else if (rst_cnt > 0) rst_cnt <= rst_cnt - 1;
        if (pin_req[0]) p0_cnt <= PIN_HOLD;
        else if (p0_cnt > 0) p0_cnt <= p0_cnt - 1;
        if (pin_req[1]) p1_cnt <= PIN_HOLD;
        else if (p1_cnt > 0) p1_cnt <= p1_cnt - 1;
    end
    assign reset_pin = (rst_cnt > 0);
    assign ext_irq_pin_zero = (p0_cnt > 0);
    assign ext_irq_pin_one = (p1_cnt > 0);
endmodule // psm_ext_model
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the power-saving mode controller
// assumes apb byte address is four times the register index
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.svh"
module tb_top;
    localparam int DEB = 8;
    localparam logic [31:0] A_PWR = `PSM_IDX_PWR_CTRL * 4;
    localparam logic [31:0] A_IE  = `PSM_IDX_IRQ_EN * 4;
    localparam logic [31:0] A_CFG = `PSM_IDX_SYS_CFG * 4;
    localparam logic [31:0] A_ST  = `PSM_IDX_STATUS * 4;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic        pready, pslverr, reset_pin, pin0, pin1, rst_req = 0;
    logic [1:0]  pin_req = 0, irq_vector_req;
    logic        irq_pending = 0, ext_mem_mode = 1, cpu_clk_en, osc_en;
    logic        als, pfs, port0_float, port2_addr, cpu_restart;
    logic [15:0] restart_pc;
    int          errors = 0, total_checks = 0;

    initial forever #5 pclk = ~pclk;

    psm_top #(.DEBOUNCE_CYC(DEB)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin(reset_pin), .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1),
        .irq_pending(irq_pending), .ext_mem_mode(ext_mem_mode), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
        .addr_latch_strobe(als), .program_fetch_strobe(pfs), .port0_float(port0_float),
        .port2_addr(port2_addr), .irq_vector_req(irq_vector_req), .cpu_restart(cpu_restart),
        .restart_pc(restart_pc));
    psm_ext_model i_ext (.pclk(pclk), .rst_req(rst_req), .pin_req(pin_req), .reset_pin(reset_pin),
        .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // setup starts one edge after entry, so a release never meets a new setup in one time step;
    // pready is sampled at the rising edge, before the design's own update lands
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
             output logic e);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(0, 1, "pready wait");
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1, a, d, r, e);
    endtask
    task rd(input logic [31:0] a, input logic [31:0] exp, input logic err_exp);
        logic [31:0] r;
        logic e;
        apb(0, a, 0, r, e);
        chk(r, exp, "read data");
        chk(e, err_exp, "slave error");
    endtask
    task pins(input logic [5:0] exp, input string what);
        @(negedge pclk);
        chk({cpu_clk_en, osc_en, als, pfs, port0_float, port2_addr}, exp, what);
        @(posedge pclk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        rd(A_PWR, 0, 0);
        rd(A_IE, 0, 0);
        rd(A_CFG, 32'h0000_0002, 0);
        rd(32'h0000_0004, 0, 1);
        wr(A_PWR, 32'h0000_000C);
        rd(A_PWR, 32'h0000_000C, 0);
        $display("test regs done");
    endtask
    task t_idle;
        int n;
        wr(A_PWR, 32'h0000_000D);
        pins(6'b011111, "idle pins");
        rd(A_PWR, 32'h0000_000C, 0);
        rd(A_ST, 1, 0);
        irq_pending <= 1;
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        irq_pending <= 0;
        chk(n < 20, 1, "idle wake");
        rd(A_ST, 0, 0);
        $display("test idle done");
    endtask
    // flags also set; both requests at once must pick power-down
    task t_pdown;
        int n;
        logic early;
        wr(A_IE, 32'h0000_0085);
        wr(A_CFG, 32'h0000_0012);
        wr(A_PWR, 32'h0000_000F);
        pins(6'b000010, "power-down pins");
        rd(A_ST, 2, 0);
        rd(A_PWR, 32'h0000_000C, 0);
        pin_req <= 2'b10;
        @(posedge pclk);
        pin_req <= 0;
        n = 0;
        early = 0;
        while (irq_vector_req === 2'b00 && n < 100) begin
            @(negedge pclk);
            n++;
            if (irq_vector_req === 2'b00 && cpu_clk_en !== 1'b0) early = 1;
        end
        chk(irq_vector_req, 2'b10, "wake vector");
        chk(early, 0, "cpu ran early");
        chk(n >= DEB, 1, "de-bounce span");
        @(posedge pclk);
        rd(A_IE, 32'h0000_0085, 0);
        $display("test power-down done");
    endtask
    task t_reset_wake;
        int n;
        wr(A_CFG, 32'h0000_0002);
        ext_mem_mode <= 0;
        wr(A_PWR, 32'h0000_0006);
        pin_req <= 2'b01;
        repeat (30) @(posedge pclk);
        pin_req <= 0;
        pins(6'b000000, "pin wake refused");
        ext_mem_mode <= 1;
        rst_req <= 1;
        @(posedge pclk);
        rst_req <= 0;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (cpu_restart !== 1'b1 && n < 100);
        chk(cpu_restart, 1, "restart pulse");
        chk(restart_pc, 16'h0000, "restart address");
        @(posedge pclk);
        rd(A_PWR, 0, 0);
        $display("test reset wake done");
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #50000;
        errors++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        t_regs;
        t_idle;
        t_pdown;
        t_reset_wake;
        close_out;
    end
endmodule // tb_top
`default_nettype wire
